// File: cism_top.sv
// clock input crosspoint, per-loop input selection and input fault monitors
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps

// Summary of operation
// - inputs 0-2 to any loop, 3-4 loop D
// - manual select from register, per-loop allowed inputs
// - manual input without clock forces holdover
// - automatic picks highest priority valid input
// - eligible only without loss or range flag
// - no eligible input gives holdover or free-run
// - per-loop hitless switch enable, else slewed
// - no hitless switching in 1 PPS mode
// - ramped switching shares holdover exit ramp rate
// - glitchless switching, pull-in at chosen bandwidth
// - lock loss asserted during pull-in
// - no runt pulses when switching inputs
// - lock to gapped input at average rate
// - valid gapped input trips no monitor
// - loss on all sources, range on four
// - shared period timing and tolerance, per-input disable
// - live and sticky loss and range status
// - crystal loss disables outputs unless kept
// - range flag merges precision and fast monitors
// - precision window in sixteenth ppm with hysteresis
// - selectable zero ppm frequency reference
// - fast monitor flags over 4000 ppm shift
// - ramp rate selectable, independent of bandwidth
module cism_top #(
  parameter int PULL_CYCLES = 4000,
  parameter int FAST_PULL_CYCLES = 500
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [cism_pkg::NUM_IN-1:0] clkIn,
  input wire logic refPin,
  input wire logic xtalPin,
  output logic [cism_pkg::NUM_LOOP-1:0] loopRefClk,
  output logic [3*cism_pkg::NUM_LOOP-1:0] loopSel,
  output logic [cism_pkg::NUM_LOOP-1:0] loopHoldover,
  output logic [cism_pkg::NUM_LOOP-1:0] loopFreeRun,
  output logic [cism_pkg::NUM_LOOP-1:0] loopLockLoss,
  output logic [cism_pkg::NUM_LOOP-1:0] loopHitless,
  output logic [cism_pkg::NUM_LOOP-1:0] loopRamped,
  output logic [cism_pkg::NUM_LOOP-1:0] loopFastPull,
  output logic [cism_pkg::RATE_W*cism_pkg::NUM_LOOP-1:0] loopRampRate,
  output logic outputsEnable
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [cism_pkg::CNT_W-1:0] ppmLimit(
    input logic [cism_pkg::CNT_W-1:0] expCnt,
    input logic [12:0] amt,
    input logic [63:0] scale
  );
    logic [63:0] prod;
    prod = 64'(expCnt) * 64'(amt);
    return cism_pkg::CNT_W'(prod / scale);
  endfunction

  // returns {found, index} of the highest non-zero priority among valid inputs
  function automatic logic [3:0] pickBest(input logic [4:0] v, input logic [14:0] pr);
    logic [2:0] bestP;
    logic [3:0] res;
    bestP = 3'h0;
    res = 4'h0;
    for (int k = 0; k < cism_pkg::NUM_IN; k++) begin
      if (v[k] && pr[k*3 +: 3] > bestP) begin
        bestP = pr[k*3 +: 3];
        res = {1'b1, 3'(k)};
      end
    end
    return res;
  endfunction

  // ****************************************
  // input sampling
  // ****************************************
  logic [cism_pkg::NUM_LOS-1:0] srcQ;
  logic [cism_pkg::NUM_LOS-1:0] srcPrevQ;
  logic [cism_pkg::NUM_LOS-1:0] srcEdge;
  assign srcEdge = srcQ & ~srcPrevQ;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      srcQ <= '0;
      srcPrevQ <= '0;
    end else if (clkEn) begin
      srcQ <= {xtalPin, refPin, clkIn};
      srcPrevQ <= srcQ;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  logic [31:0] ctrlQ [cism_pkg::NUM_LOOP];
  logic [31:0] prioQ [cism_pkg::NUM_LOOP];
  logic [31:0] losCfgQ, freqCfgQ, gateQ, expQ;
  logic [cism_pkg::LIVE_W-1:0] stickyQ;
  logic [cism_pkg::NUM_LOS-1:0] losLive;
  logic [cism_pkg::NUM_FREQ-1:0] freqLive;
  logic [cism_pkg::NUM_LOOP-1:0] lolLive;
  logic [cism_pkg::LIVE_W-1:0] live;
  logic [31:0] stateWord;
  logic [31:0] rdData;
  logic mapped;
  logic wrDone;
  assign live = {lolLive, freqLive, losLive};
  assign wrDone = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    rdData = '0;
    mapped = 1'b1;
    case (paddr)
      cism_pkg::ADDR_CTRL0: rdData = ctrlQ[0];
      cism_pkg::ADDR_CTRL1: rdData = ctrlQ[1];
      cism_pkg::ADDR_CTRL2: rdData = ctrlQ[2];
      cism_pkg::ADDR_PRIO0: rdData = prioQ[0];
      cism_pkg::ADDR_PRIO1: rdData = prioQ[1];
      cism_pkg::ADDR_PRIO2: rdData = prioQ[2];
      cism_pkg::ADDR_LOS_CFG: rdData = losCfgQ;
      cism_pkg::ADDR_FREQ_CFG: rdData = freqCfgQ;
      cism_pkg::ADDR_FREQ_GATE: rdData = gateQ;
      cism_pkg::ADDR_FREQ_EXP: rdData = expQ;
      cism_pkg::ADDR_LIVE: rdData = 32'(live);
      cism_pkg::ADDR_STICKY: rdData = 32'(stickyQ);
      cism_pkg::ADDR_STATE: rdData = stateWord;
      default: mapped = 1'b0;
    endcase
  end

  // answer one cycle into the access phase so prdata and pready are both flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rdData;
        pslverr <= ~mapped;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < cism_pkg::NUM_LOOP; i++) begin
        ctrlQ[i] <= cism_pkg::CTRL_RST;
        prioQ[i] <= cism_pkg::PRIO_RST;
      end
      losCfgQ <= cism_pkg::LOS_RST;
      freqCfgQ <= cism_pkg::FREQ_RST;
      gateQ <= cism_pkg::GATE_RST;
      expQ <= cism_pkg::EXP_RST;
    end else if (clkEn && wrDone) begin
      case (paddr)
        cism_pkg::ADDR_CTRL0: ctrlQ[0] <= pwdata & cism_pkg::CTRL_MASK;
        cism_pkg::ADDR_CTRL1: ctrlQ[1] <= pwdata & cism_pkg::CTRL_MASK;
        cism_pkg::ADDR_CTRL2: ctrlQ[2] <= pwdata & cism_pkg::CTRL_MASK;
        cism_pkg::ADDR_PRIO0: prioQ[0] <= pwdata & cism_pkg::PRIO_MASK;
        cism_pkg::ADDR_PRIO1: prioQ[1] <= pwdata & cism_pkg::PRIO_MASK;
        cism_pkg::ADDR_PRIO2: prioQ[2] <= pwdata & cism_pkg::PRIO_MASK;
        cism_pkg::ADDR_LOS_CFG: losCfgQ <= pwdata & cism_pkg::LOS_MASK;
        cism_pkg::ADDR_FREQ_CFG: freqCfgQ <= pwdata & cism_pkg::FREQ_MASK;
        cism_pkg::ADDR_FREQ_GATE: gateQ <= pwdata & cism_pkg::GATE_MASK;
        cism_pkg::ADDR_FREQ_EXP: expQ <= pwdata & cism_pkg::EXP_MASK;
        default: ;
      endcase
    end
  end

  // set wins over the clear so an event in the clearing cycle is kept
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stickyQ <= '0;
    end else if (clkEn) begin
      if (wrDone && paddr == cism_pkg::ADDR_STICKY) begin
        stickyQ <= (stickyQ & ~pwdata[cism_pkg::LIVE_W-1:0]) | live;
      end else begin
        stickyQ <= stickyQ | live;
      end
    end
  end

  // ****************************************
  // signal loss monitors
  // ****************************************
  logic [11:0] losLim;
  logic [3:0] losTol;
  assign losLim = losCfgQ[cism_pkg::LOS_LIM +: 12];
  assign losTol = losCfgQ[cism_pkg::LOS_TOL +: 4];

  // one monitor per clock input, reference pins and crystal pins
  for (genvar i = 0; i < cism_pkg::NUM_LOS; i++) begin : g_los
    logic [11:0] perCntQ;
    logic [3:0] missQ;
    always_ff @(posedge core_clk) begin
      if (reset) begin
        perCntQ <= '0;
        missQ <= '0;
        losLive[i] <= 1'b0;
      end else if (clkEn) begin
        if (losCfgQ[i]) begin
          perCntQ <= '0;
          missQ <= '0;
          losLive[i] <= 1'b0;
        end else if (srcEdge[i]) begin
          perCntQ <= '0;
          missQ <= '0;
          losLive[i] <= 1'b0;
        end else if (perCntQ >= losLim) begin
          perCntQ <= '0;
          if (missQ != 4'hf) begin
            missQ <= missQ + 4'h1;
          end
          // a gapped source skips at most the tolerated number of periods
          if (missQ >= losTol) begin
            losLive[i] <= 1'b1;
          end
        end else begin
          perCntQ <= perCntQ + 12'h001;
        end
      end
    end
  end

  // ****************************************
  // frequency range monitors
  // ****************************************
  logic [2:0] refSel;
  logic [12:0] winEff, hystEff, clrAmt;
  logic [cism_pkg::CNT_W-1:0] precLim, clrLim, fastLim, expCnt;
  logic refEdgeSel;
  assign refSel = freqCfgQ[cism_pkg::FRQ_REFSEL +: 3];
  assign expCnt = expQ[cism_pkg::CNT_W-1:0];

  always_comb begin
    case (refSel)
      cism_pkg::REFSEL_PINS: refEdgeSel = srcEdge[cism_pkg::LOS_REF];
      3'h1: refEdgeSel = srcEdge[0];
      3'h2: refEdgeSel = srcEdge[1];
      3'h3: refEdgeSel = srcEdge[2];
      cism_pkg::REFSEL_XTAL: refEdgeSel = srcEdge[cism_pkg::LOS_XTAL];
      default: refEdgeSel = srcEdge[cism_pkg::LOS_REF];
    endcase
  end

  always_comb begin
    winEff = freqCfgQ[cism_pkg::FRQ_WIN +: 13];
    if (winEff > cism_pkg::WIN_MAX) begin
      winEff = cism_pkg::WIN_MAX;
    end
    hystEff = freqCfgQ[cism_pkg::FRQ_HYST +: 13];
    if (hystEff > winEff) begin
      hystEff = winEff;
    end
    clrAmt = winEff - hystEff;
  end

  assign precLim = ppmLimit(expCnt, winEff, cism_pkg::SIXTEENTH_SCALE);
  assign clrLim = ppmLimit(expCnt, clrAmt, cism_pkg::SIXTEENTH_SCALE);
  assign fastLim = ppmLimit(expCnt, cism_pkg::FAST_PPM, cism_pkg::PPM_SCALE);

  // inputs 0-2 and the reference pins; the pins check against the crystal when they are the reference
  for (genvar j = 0; j < cism_pkg::NUM_FREQ; j++) begin : g_freq
    localparam int SRC = (j < 3) ? j : cism_pkg::LOS_REF;
    logic chRef;
    logic gateEnd;
    logic [15:0] gateCntQ;
    logic [cism_pkg::CNT_W-1:0] edgeCntQ, diff;
    logic precQ, fastQ;
    assign chRef = (j == 3 && refSel == cism_pkg::REFSEL_PINS) ? srcEdge[cism_pkg::LOS_XTAL] : refEdgeSel;
    assign gateEnd = chRef && (gateCntQ + 16'h0001 >= gateQ[15:0]);
    assign diff = (edgeCntQ > expCnt) ? edgeCntQ - expCnt : expCnt - edgeCntQ;
    always_ff @(posedge core_clk) begin
      if (reset) begin
        gateCntQ <= '0;
        edgeCntQ <= '0;
        precQ <= 1'b0;
        fastQ <= 1'b0;
      end else if (clkEn) begin
        if (gateEnd) begin
          gateCntQ <= '0;
          edgeCntQ <= cism_pkg::CNT_W'(srcEdge[SRC]);
          // hysteresis: clear only once well back inside the window
          if (!precQ && diff > precLim) begin
            precQ <= 1'b1;
          end else if (precQ && diff <= clrLim) begin
            precQ <= 1'b0;
          end
          fastQ <= diff > fastLim;
        end else begin
          gateCntQ <= gateCntQ + 16'(chRef);
          edgeCntQ <= edgeCntQ + cism_pkg::CNT_W'(srcEdge[SRC]);
        end
      end
    end
    always_ff @(posedge core_clk) begin
      if (reset) begin
        freqLive[j] <= 1'b0;
      end else if (clkEn) begin
        freqLive[j] <= (precQ & ~freqCfgQ[cism_pkg::FRQ_PREC_DIS]) | (fastQ & ~freqCfgQ[cism_pkg::FRQ_FAST_DIS]);
      end
    end
  end

  // ****************************************
  // crystal loss output gate
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      outputsEnable <= 1'b0;
    end else if (clkEn) begin
      outputsEnable <= ~(losLive[cism_pkg::LOS_XTAL] & ~losCfgQ[cism_pkg::LOS_KEEP]);
    end
  end

  // ****************************************
  // per-loop selection
  // ****************************************
  for (genvar l = 0; l < cism_pkg::NUM_LOOP; l++) begin : g_loop
    localparam logic [4:0] ELIG = cism_pkg::ELIG_MASK[l*5 +: 5];
    logic [31:0] ctl;
    logic [4:0] valid;
    logic [3:0] best;
    logic [2:0] man, tgt;
    logic tgtOk, pps;
    logic [15:0] pullLen, pullCntQ;
    logic [2:0] selQ, muxSelQ;
    logic refClkQ, lolQ, hitQ, rampQ, fastQ;
    logic [cism_pkg::RATE_W-1:0] rateQ;
    cism_pkg::cism_loop_e stateQ;
    assign ctl = ctrlQ[l];
    assign man = ctl[cism_pkg::CTRL_SEL +: 3];
    assign pps = ctl[cism_pkg::CTRL_PPS];
    assign valid = ~losLive[4:0] & ~{2'b00, freqLive[2:0]} & ELIG;
    assign best = pickBest(valid, prioQ[l][14:0]);
    assign pullLen = ctl[cism_pkg::CTRL_FAST] ? 16'(FAST_PULL_CYCLES) : 16'(PULL_CYCLES);

    always_comb begin
      tgt = selQ;
      tgtOk = 1'b0;
      if (ctl[cism_pkg::CTRL_AUTO]) begin
        // non-revertive keeps a still-valid input even if a better one returns
        if (stateQ == cism_pkg::ST_LOCK && valid[selQ] && !ctl[cism_pkg::CTRL_REV]) begin
          tgtOk = 1'b1;
        end else if (best[3]) begin
          tgt = best[2:0];
          tgtOk = 1'b1;
        end
      end else begin
        tgt = man;
        tgtOk = (man < 3'h5) ? (ELIG[man] & ~losLive[man]) : 1'b0;
      end
    end

    always_ff @(posedge core_clk) begin
      if (reset) begin
        stateQ <= cism_pkg::ST_FREE;
        selQ <= '0;
        pullCntQ <= '0;
      end else if (clkEn) begin
        if (pullCntQ != 16'h0000) begin
          pullCntQ <= pullCntQ - 16'h0001;
        end
        case (stateQ)
          cism_pkg::ST_FREE: begin
            if (tgtOk) begin
              stateQ <= cism_pkg::ST_LOCK;
              selQ <= tgt;
              pullCntQ <= pullLen;
            end
          end
          cism_pkg::ST_LOCK: begin
            if (!tgtOk) begin
              stateQ <= cism_pkg::ST_HOLD;
            end else if (tgt != selQ) begin
              selQ <= tgt;
              pullCntQ <= pullLen;
            end
          end
          cism_pkg::ST_HOLD: begin
            if (tgtOk) begin
              stateQ <= cism_pkg::ST_LOCK;
              selQ <= tgt;
              pullCntQ <= pullLen;
            end
          end
          default: stateQ <= cism_pkg::ST_FREE;
        endcase
      end
    end

    // gapped inputs pass straight through; the loop filter averages them
    always_ff @(posedge core_clk) begin
      if (reset) begin
        lolQ <= 1'b1;
        hitQ <= 1'b0;
        rampQ <= 1'b0;
        fastQ <= 1'b0;
        rateQ <= '0;
      end else if (clkEn) begin
        // built from next-state terms so lock loss rises on the same edge as a new selection or holdover
        lolQ <= ~tgtOk | (stateQ != cism_pkg::ST_LOCK) | (tgt != selQ) | (pullCntQ > 16'h0001);
        hitQ <= ctl[cism_pkg::CTRL_HITLESS] & ~pps;
        rampQ <= ctl[cism_pkg::CTRL_RAMP] & ~pps;
        fastQ <= ctl[cism_pkg::CTRL_FAST];
        rateQ <= ctl[cism_pkg::CTRL_RATE +: cism_pkg::RATE_W];
      end
    end

    // switch the mux only while the output is low and restart on a true rising edge
    always_ff @(posedge core_clk) begin
      if (reset) begin
        muxSelQ <= '0;
        refClkQ <= 1'b0;
      end else if (clkEn) begin
        if (refClkQ) begin
          refClkQ <= srcQ[muxSelQ];
        end else if (muxSelQ != selQ) begin
          muxSelQ <= selQ;
        end else begin
          refClkQ <= (stateQ == cism_pkg::ST_LOCK) & srcQ[muxSelQ] & ~srcPrevQ[muxSelQ];
        end
      end
    end

    assign loopSel[l*3 +: 3] = selQ;
    assign loopHoldover[l] = stateQ[2];
    assign loopFreeRun[l] = stateQ[0];
    assign loopLockLoss[l] = lolQ;
    assign lolLive[l] = lolQ;
    assign loopHitless[l] = hitQ;
    assign loopRamped[l] = rampQ;
    assign loopFastPull[l] = fastQ;
    assign loopRampRate[l*cism_pkg::RATE_W +: cism_pkg::RATE_W] = rateQ;
    assign loopRefClk[l] = refClkQ;
    assign stateWord[l*cism_pkg::STATE_STRIDE +: cism_pkg::STATE_STRIDE] =
      {3'h0, stateQ[0], stateQ[2], selQ};
  end
  assign stateWord[31:cism_pkg::NUM_LOOP*cism_pkg::STATE_STRIDE] = '0;
endmodule

// File: cism_pkg.sv
// constants, register map and types for the clock input select and monitor block
package cism_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_IN = 5;
  localparam int NUM_LOOP = 3;
  localparam int NUM_LOS = 7;
  localparam int NUM_FREQ = 4;
  localparam int CNT_W = 24;
  localparam int LIVE_W = 14;
  localparam int LOS_REF = 5;
  localparam int LOS_XTAL = 6;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_PRIO0 = 8'h0c;
  localparam logic [7:0] ADDR_PRIO1 = 8'h10;
  localparam logic [7:0] ADDR_PRIO2 = 8'h14;
  localparam logic [7:0] ADDR_LOS_CFG = 8'h18;
  localparam logic [7:0] ADDR_FREQ_CFG = 8'h1c;
  localparam logic [7:0] ADDR_FREQ_GATE = 8'h20;
  localparam logic [7:0] ADDR_FREQ_EXP = 8'h24;
  localparam logic [7:0] ADDR_LIVE = 8'h28;
  localparam logic [7:0] ADDR_STICKY = 8'h2c;
  localparam logic [7:0] ADDR_STATE = 8'h30;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_SEL = 0;
  localparam int CTRL_AUTO = 3;
  localparam int CTRL_REV = 4;
  localparam int CTRL_HITLESS = 5;
  localparam int CTRL_RAMP = 6;
  localparam int CTRL_PPS = 7;
  localparam int CTRL_FAST = 8;
  localparam int CTRL_RATE = 9;
  localparam int RATE_W = 6;
  localparam int LOS_KEEP = 7;
  localparam int LOS_TOL = 8;
  localparam int LOS_LIM = 16;
  localparam int FRQ_PREC_DIS = 0;
  localparam int FRQ_FAST_DIS = 1;
  localparam int FRQ_REFSEL = 2;
  localparam int FRQ_WIN = 5;
  localparam int FRQ_HYST = 18;
  localparam int LIVE_FREQ = 7;
  localparam int LIVE_LOL = 11;
  localparam int STATE_STRIDE = 8;
  localparam int STATE_HOLD = 3;
  localparam int STATE_FREE = 4;

  // ****************************************
  // write masks and reset values
  // ****************************************
  localparam logic [31:0] CTRL_MASK = 32'h0000_7fff;
  localparam logic [31:0] PRIO_MASK = 32'h0000_7fff;
  localparam logic [31:0] LOS_MASK = 32'h0fff_0fff;
  localparam logic [31:0] FREQ_MASK = 32'h7fff_ffff;
  localparam logic [31:0] GATE_MASK = 32'h0000_ffff;
  localparam logic [31:0] EXP_MASK = 32'h00ff_ffff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0040;
  localparam logic [31:0] PRIO_RST = 32'h0000_0000;
  localparam logic [31:0] LOS_RST = 32'h0010_0200;
  localparam logic [31:0] FREQ_RST = 32'h0003_e800;
  localparam logic [31:0] GATE_RST = 32'h0000_0100;
  localparam logic [31:0] EXP_RST = 32'h0000_0100;

  // ****************************************
  // selection and frequency constants
  // ****************************************
  localparam logic [14:0] ELIG_MASK = 15'h7ce7;
  localparam logic [2:0] REFSEL_PINS = 3'h0;
  localparam logic [2:0] REFSEL_XTAL = 3'h4;
  localparam logic [12:0] WIN_MAX = 13'h1f40;
  localparam logic [12:0] FAST_PPM = 13'hfa0;
  localparam logic [63:0] SIXTEENTH_SCALE = 64'h0000_0000_00f4_2400;
  localparam logic [63:0] PPM_SCALE = 64'h0000_0000_000f_4240;

  typedef enum logic [2:0] {
    ST_FREE = 3'b001,
    ST_LOCK = 3'b010,
    ST_HOLD = 3'b100
  } cism_loop_e;
endpackage

// File: cism_top_asserts.sv
// concurrent checks on the select and monitor block ports
`timescale 1ns/100ps
module cism_top_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [8:0] loopSel,
  input wire logic [2:0] loopHoldover,
  input wire logic [2:0] loopFreeRun,
  input wire logic [2:0] loopLockLoss,
  input wire logic [2:0] loopHitless,
  input wire logic [2:0] loopRamped,
  input wire logic [2:0] loopFastPull,
  input wire logic [17:0] loopRampRate,
  input wire logic outputsEnable
);
  // **********
  // shadow copies of written control words
  // **********
  logic wrDone;
  logic wrA;
  logic [31:0] ctrlA_q;
  logic [31:0] ctrlD_q;
  logic [31:0] losCfg_q;
  assign wrDone = psel && penable && pready && pwrite;
  assign wrA = wrDone && paddr == cism_pkg::ADDR_CTRL0;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrlA_q <= cism_pkg::CTRL_RST;
      ctrlD_q <= cism_pkg::CTRL_RST;
      losCfg_q <= cism_pkg::LOS_RST;
    end else begin
      ctrlA_q <= wrA ? pwdata : ctrlA_q;
      ctrlD_q <= (wrDone && paddr == cism_pkg::ADDR_CTRL2) ? pwdata : ctrlD_q;
      losCfg_q <= (wrDone && paddr == cism_pkg::ADDR_LOS_CFG) ? pwdata : losCfg_q;
    end
  end
  // **********
  // properties
  // **********
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence apb_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  apb_timing_a:
    assert property (psel && !penable |=> apb_answer) else $error("apb access not answered in two cycles");
  bad_addr_a:
    assert property (pready |-> pslverr == (paddr > cism_pkg::ADDR_STATE || paddr[1:0] != 2'h0)
      && (!pslverr || prdata == 32'h0)) else $error("slave error or its read data wrong");
  ctrl_copy_a:
    assert property ($past(wrA, 2) |-> loopHitless[0] == (ctrlA_q[5] && !ctrlA_q[7])
      && loopRamped[0] == (ctrlA_q[6] && !ctrlA_q[7]) && loopFastPull[0] == ctrlA_q[8]
      && loopRampRate[5:0] == ctrlA_q[14:9]) else $error("loop A control copy wrong");
  pps_nohit_a:
    assert property (ctrlD_q[7] && $past(ctrlD_q[7]) |-> !loopHitless[2] && !loopRamped[2])
      else $error("hitless or ramp active in pps mode");
  sel_range_a:
    assert property (!loopHoldover[0] && !loopFreeRun[0] |-> loopSel[2:0] <= 3'h2)
      else $error("loop A locked to a cmos-only input");
  pull_lol_a:
    assert property ($changed(loopSel[2:0]) |-> loopLockLoss[0] [*4]) else $error("lock loss dropped during pull-in");
  idle_lol_a:
    assert property (loopHoldover[2] || loopFreeRun[2] |-> loopLockLoss[2]) else $error("lock loss low while unlocked");
  keep_out_a:
    assert property (losCfg_q[7] && $past(losCfg_q[7]) |-> outputsEnable) else $error("outputs off despite keep");
endmodule
bind cism_top cism_top_asserts u_cism_top_asserts (.core_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pready, .prdata, .pslverr, .loopSel, .loopHoldover, .loopFreeRun, .loopLockLoss, .loopHitless, .loopRamped,
  .loopFastPull, .loopRampRate, .outputsEnable);

// File: cism_src.sv
// model of the clock sources, reference pins and crystal feeding the block
`timescale 1ns/100ps
module cism_src (
  input wire logic core_clk,
  input wire logic [6:0] srcRun,
  input wire logic [6:0] srcSlow,
  output logic [4:0] clkIn,
  output logic refPin,
  output logic xtalPin
);
  logic [1:0] phase_q = 2'h0;
  logic [6:0] level;
  always_ff @(posedge core_clk) begin
    phase_q <= phase_q + 2'h1;
  end
  // one shared counter keeps all sources in phase, so the edge counts are exact
  // a stopped source rests low, as a pulled-down pin would
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      level[k] = srcRun[k] & (srcSlow[k] ? phase_q[1] : phase_q[0]);
    end
  end
  assign clkIn = level[4:0];
  assign refPin = level[5];
  assign xtalPin = level[6];
endmodule

// File: cism_top_bench.sv
// testbench: apb register tasks driving the select and monitor block
`timescale 1ns/100ps
module cism_top_bench;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, refPin, xtalPin, outputsEnable, rdErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [4:0] clkIn;
  logic [2:0] loopHoldover, loopFreeRun, loopHitless, loopRamped, loopFastPull, loopRefClk, loopLockLoss;
  logic [8:0] loopSel;
  logic [17:0] loopRampRate;
  logic [6:0] srcRun, srcSlow;
  int nErrors;
  int testsRun;
  logic [7:0] regAddr [5] = '{cism_pkg::ADDR_CTRL0, cism_pkg::ADDR_PRIO1, cism_pkg::ADDR_LOS_CFG,
    cism_pkg::ADDR_FREQ_CFG, cism_pkg::ADDR_FREQ_GATE};
  logic [31:0] regRst [5] = '{cism_pkg::CTRL_RST, cism_pkg::PRIO_RST, cism_pkg::LOS_RST, cism_pkg::FREQ_RST,
    cism_pkg::GATE_RST};
  cism_top #(.PULL_CYCLES(20), .FAST_PULL_CYCLES(5)) u_cism_top (.core_clk, .reset, .clkEn(1'b1), .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr, .clkIn, .refPin, .xtalPin, .loopRefClk, .loopSel,
    .loopHoldover, .loopFreeRun, .loopLockLoss, .loopHitless, .loopRamped, .loopFastPull, .loopRampRate,
    .outputsEnable);
  cism_src u_cism_src (.core_clk, .srcRun, .srcSlow, .clkIn, .refPin, .xtalPin);
  // **********
  // tasks
  // **********
  task stop_test;
    $display("mismatches %0d of %0d checks", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one apb transfer, entered just after a rising edge; holds the request until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // **********
  // clock, watchdog and scenarios
  // **********
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    wt(10000);
    nErrors++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, srcSlow} = '0;
    srcRun = 7'h7f;
    reset = 1'b1;
    wt(3);
    reset <= 1'b0;
    wt(1);
    foreach (regAddr[i]) begin
      apb(1'b0, regAddr[i], 32'h0);
      chk(rdVal, regRst[i], "reset value");
    end
    apb(1'b0, 8'h34, 32'h0);
    chk({rdErr, rdVal[30:0]}, 32'h8000_0000, "unmapped read");
    $display("test registers done");
    // precision monitor off: sources share one counter, the fast monitor alone judges range
    apb(1'b1, cism_pkg::ADDR_FREQ_CFG, cism_pkg::FREQ_RST | 32'h1);
    apb(1'b1, cism_pkg::ADDR_CTRL2, 32'h44);
    apb(1'b1, cism_pkg::ADDR_CTRL0, 32'h44);
    wt(60);
    chk(loopSel[8:6], 32'h4, "loop D manual input 4");
    chk(loopHoldover[0] | loopFreeRun[0], 32'h1, "loop A refuses input 4");
    srcRun[4] <= 1'b0;
    wt(100);
    chk(loopHoldover[2], 32'h1, "manual input lost");
    $display("test manual done");
    apb(1'b1, cism_pkg::ADDR_PRIO0, 32'he9);
    apb(1'b1, cism_pkg::ADDR_CTRL0, 32'h48);
    wt(60);
    chk(loopSel[2:0], 32'h1, "highest priority");
    srcRun[1] <= 1'b0;
    wt(100);
    chk(loopSel[2:0], 32'h2, "next priority after loss");
    srcSlow[2] <= 1'b1;
    wt(1300);
    chk(loopSel[2:0], 32'h0, "range flag excludes input");
    apb(1'b0, cism_pkg::ADDR_LIVE, 32'h0);
    chk(rdVal & 32'h212, 32'h212, "live loss and range");
    srcRun[0] <= 1'b0;
    wt(100);
    chk(loopHoldover[0], 32'h1, "no valid input left");
    chk({loopRefClk[0], loopLockLoss[0]}, 32'h1, "holdover clock and lock loss");
    $display("test auto done");
    apb(1'b1, cism_pkg::ADDR_STICKY, 32'h1);
    apb(1'b0, cism_pkg::ADDR_STICKY, 32'h0);
    chk(rdVal[0], 32'h1, "sticky sets again");
    srcRun[1] <= 1'b1;
    wt(100);
    apb(1'b0, cism_pkg::ADDR_LIVE, 32'h0);
    chk(rdVal[1], 32'h0, "live loss gone");
    apb(1'b0, cism_pkg::ADDR_STICKY, 32'h0);
    chk(rdVal[1], 32'h1, "sticky loss kept");
    apb(1'b1, cism_pkg::ADDR_STICKY, 32'h2);
    apb(1'b0, cism_pkg::ADDR_STICKY, 32'h0);
    chk(rdVal[1], 32'h0, "sticky cleared");
    $display("test status done");
    srcRun[6] <= 1'b0;
    wt(100);
    chk(outputsEnable, 32'h0, "crystal loss stops outputs");
    apb(1'b1, cism_pkg::ADDR_LOS_CFG, cism_pkg::LOS_RST | 32'h80);
    wt(2);
    chk(outputsEnable, 32'h1, "keep outputs");
    $display("test crystal done");
    apb(1'b1, cism_pkg::ADDR_CTRL1, 32'h5560);
    apb(1'b1, cism_pkg::ADDR_CTRL2, 32'he4);
    wt(2);
    chk({loopHitless, loopRamped, loopFastPull}, 32'h09a, "switch modes");
    chk(loopRampRate[11:6], 32'h2a, "ramp rate");
    $display("test control done");
    stop_test();
  end
endmodule
